/* testbench.sv */
`timescale 1ns/1ps
`include "wtc_defs.svh"
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin \
  miscompares++; $display("[FAIL] %s exp %0h got %0h", nm, ex, sn); end end
//////////////////////////////////////////////////////////////////////////////
module testbench;
  import wtc_pkg::*;
  logic        clk_i = 0;
  logic        rst_i = 1;
  wtc_wb_req_t req   = '0;
  logic [9:0]  lvl   = '0;
  logic        rdy   = 0;
  logic [3:0]  cns   = '0;
  logic [3:0]  clr   = '0;
  logic [31:0] rdat, rd;
  logic        ack, gen, vld, st;
  logic [1:0]  fpi;
  logic [7:0]  bpt, sa;
  logic [3:0]  scr;
  int          miscompares = 0;
  int          num_checks  = 0;
  int          starts      = 0;
  int          s0;

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (st === 1'b1) starts <= starts + 1;

  wtc_ext_trig u_wtc_ext_trig (.lvl_i(lvl), .front_o(fpi), .back_o(bpt));
  wtc_trigger_ctrl u_wtc_trigger_ctrl (
    .clk_i, .rst_i, .wb_dat_i(req.dat), .wb_adr_i(req.adr),
    .wb_sel_i(req.sel), .wb_we_i(req.we), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .front_programmable_input_i(fpi), .backplane_trig_i(bpt),
    .scr_ready_i(rdy), .scr_consume_i(cns), .scr_clear_i(clr),
    .scr_trig_o(scr), .generating_o(gen), .sample_addr_o(sa),
    .sample_valid_o(vld), .start_trig_o(st)
  );

  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (ack === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      close_out();
    end
    rd = rdat;
    req <= '0;
    @(posedge clk_i);
  endtask : bus

  task automatic meas(input int el, input logic [7:0] last);
    int n;
    int len;
    for (n = 0; n < 30 && gen !== 1'b1; n++) @(posedge clk_i);
    if (n == 30) begin
      miscompares++;
      close_out();
    end
    for (len = 0; len < 200 && gen === 1'b1; len++) @(posedge clk_i);
    `CHK("gen_len", el, len)
    if (el < 200) `CHK("hold", {1'b1, last}, {vld, sa})
  endtask : meas

  task automatic run(input logic [31:0] tc, input logic [31:0] gc);
    bus(1, `WTC_ADR_CTRL, 32'h0000_0002);
    bus(1, `WTC_ADR_TRIGCFG, tc);
    bus(1, `WTC_ADR_GENCFG, gc);
    bus(1, `WTC_ADR_CTRL, 32'h0000_0001);
  endtask : run

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    `CHK("idle", 15'h0000, {gen, vld, st, sa, scr})
    bus(0, `WTC_ADR_GENCFG, 32'h0000_0000);
    `CHK("gencfg", `WTC_GENCFG_RST, rd)
    bus(0, `WTC_ADR_TRIGCFG, 32'h0000_0000);
    `CHK("trigcfg", `WTC_TRIGCFG_RST, rd)
    bus(1, 8'h40, 32'hffff_ffff);
    bus(0, 8'h40, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, rd)
  endtask : t_reset

  task automatic t_gate;
    bus(1, `WTC_ADR_TRIGCFG, 32'h0000_0001);
    s0 = starts;
    lvl[0] <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK("gated", s0, starts)
    bus(0, `WTC_ADR_CTRL, 32'h0000_0000);
    `CHK("not_init", 32'h0000_0000, rd)
    lvl[0] <= 1'b0;
  endtask : t_gate

  task automatic t_imm;
    s0 = starts;
    run(32'h0000_0000, 32'h0201_0004);
    repeat (6) @(posedge clk_i);
    `CHK("not_ready", s0, starts)
    rdy <= 1'b1;
    meas(6, 8'h02);
    `CHK("imm_once", s0 + 1, starts)
  endtask : t_imm

  task automatic t_single;
    run(32'h0000_0020, 32'h0400_0100);
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    meas(10, 8'h04);
    s0 = starts;
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    repeat (6) @(posedge clk_i);
    `CHK("single_ign", s0, starts)
    `CHK("still_hold", 9'h104, {vld, sa})
    bus(0, `WTC_ADR_STATUS, 32'h0000_0000);
    `CHK("status_hold", 32'h0000_0003, rd)
    bus(0, `WTC_ADR_SAMPLE, 32'h0000_0000);
    `CHK("sample_reg", 32'h0000_0004, rd)
  endtask : t_single

  task automatic t_modes;
    run(32'h0000_0020, 32'h0200_0002);
    s0 = starts;
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    meas(3, 8'h02);
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    meas(3, 8'h02);
    `CHK("steps", s0 + 2, starts)
    run(32'h0000_0000, 32'h0300_0003);
    meas(4, 8'h03);
    run(32'h0000_0020, 32'h0201_0006);
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    meas(3, 8'h02);
    bus(1, `WTC_ADR_CMD, 32'h0000_0001);
    meas(3, 8'h02);
    run(32'h0000_0000, 32'h0201_0005);
    meas(200, 8'h00);
    run(32'h0000_0000, 32'h0400_0001);
    meas(200, 8'h00);
  endtask : t_modes

  task automatic t_edge;
    int s;
    int p;
    for (s = 1; s <= 10; s++) begin
      for (p = 0; p < 2; p++) begin
        lvl[s-1] <= ~p[0];
        run(32'(s | (p << 4)), 32'h0400_0000);
        s0 = starts;
        lvl[s-1] <= p[0];
        repeat (6) @(posedge clk_i);
        `CHK("wrong_edge", s0, starts)
        lvl[s-1] <= ~p[0];
        meas(5, 8'h04);
        `CHK("one_event", s0 + 1, starts)
        lvl[s-1] <= 1'b0;
      end
    end
  endtask : t_edge

  task automatic t_script;
    run(32'h0009_2400, 32'h0400_0000);
    lvl[0] <= 1'b1;
    repeat (5) @(posedge clk_i);
    `CHK("scr_on", 2'h3, scr[1:0])
    lvl[0] <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK("scr_latch", 2'h1, scr[1:0])
    cns <= 4'h1;
    @(posedge clk_i);
    cns <= 4'h0;
    repeat (2) @(posedge clk_i);
    `CHK("consumed", 1'b0, scr[0])
    bus(1, `WTC_ADR_CMD, 32'h0000_0040);
    repeat (2) @(posedge clk_i);
    `CHK("scr_soft", 1'b1, scr[2])
    bus(0, `WTC_ADR_SCRIPT, 32'h0000_0000);
    `CHK("scr_reg", 32'h0000_0004, rd)
    clr <= 4'h4;
    @(posedge clk_i);
    clr <= 4'h0;
    repeat (2) @(posedge clk_i);
    `CHK("cleared", 1'b0, scr[2])
  endtask : t_script

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_gate();
    t_imm();
    t_single();
    t_modes();
    t_edge();
    t_script();
    close_out();
  end
endmodule : testbench

/* wtc_defs.svh */
`ifndef WTC_DEFS_SVH
`define WTC_DEFS_SVH

// Register byte offsets
`define WTC_ADR_CTRL      8'h00
`define WTC_ADR_TRIGCFG   8'h04
`define WTC_ADR_GENCFG    8'h08
`define WTC_ADR_CMD       8'h0C
`define WTC_ADR_SCRIPT    8'h10
`define WTC_ADR_STATUS    8'h14
`define WTC_ADR_SAMPLE    8'h18

// CTRL fields
`define WTC_CTRL_INIT_BIT   0
`define WTC_CTRL_ABORT_BIT  1

// TRIGCFG fields: start source/polarity, script type/source/polarity
`define WTC_START_SRC_LSB   0
`define WTC_START_POL_BIT   4
`define WTC_START_SW_BIT    5
`define WTC_SCR_TYPE_LSB    8
`define WTC_SCR_SRC_LSB     16
`define WTC_SCR_POL_LSB     28

// GENCFG fields
`define WTC_TMODE_LSB       0
`define WTC_OMODE_BIT       2
`define WTC_REPEAT_LSB      8
`define WTC_SEGS_LSB        16
`define WTC_WLEN_LSB        24

// CMD fields
`define WTC_CMD_SWSTART_BIT 0
`define WTC_CMD_SWSCR_LSB   4

// Reset values
`define WTC_TRIGCFG_RST     32'h0000_0000
`define WTC_GENCFG_RST      32'h0400_0000

`endif

/* wtc_ext_trig.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// External trigger circuitry: clean digital levels on the trigger pins
module wtc_ext_trig (
  input  wire logic [9:0] lvl_i,
  output logic      [1:0] front_o,
  output logic      [7:0] back_o
);
  assign front_o = lvl_i[1:0];
  assign back_o  = lvl_i[9:2];
endmodule : wtc_ext_trig

/* wtc_pkg.sv */
package wtc_pkg;

  // Source select: 0 immediate, 1..2 front inputs, 3..10 backplane lines
  typedef logic [3:0] wtc_src_t;

  typedef enum logic [1:0] {
    WTC_TYPE_EDGE  = 2'h0,
    WTC_TYPE_LEVEL = 2'h1,
    WTC_TYPE_SOFT  = 2'h2
  } wtc_ttype_t;

  typedef enum logic [1:0] {
    WTC_TM_SINGLE     = 2'h0,
    WTC_TM_CONTINUOUS = 2'h1,
    WTC_TM_STEPPED    = 2'h2,
    WTC_TM_BURST      = 2'h3
  } wtc_tmode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wtc_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wtc_wb_rsp_t;

  // Script engine consume/clear requests, one bit per script trigger
  typedef struct packed {
    logic [3:0] consume;
    logic [3:0] clear;
  } wtc_scr_ctl_t;

endpackage : wtc_pkg

/* wtc_properties.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module wtc_properties
  import wtc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_ack_o,
  input  wire logic       generating_o,
  input  wire logic       sample_valid_o,
  input  wire logic [7:0] sample_addr_o,
  input  wire logic       start_trig_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    start_trig_o ##1 generating_o;
  endsequence
  sequence s_hold;
    (sample_valid_o && !generating_o) ##1 (sample_valid_o && !generating_o);
  endsequence
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  AST_START_GEN: assert property (start_trig_o |-> s_take)
    else $error("start did not begin generation");
  AST_GEN_CAUSE: assert property (
    $rose(generating_o) |-> $past(start_trig_o))
    else $error("generation without start");
  AST_START_ONE: assert property (start_trig_o |=> !start_trig_o)
    else $error("start event longer than one cycle");
  AST_BUSY_IGN: assert property (
    generating_o && $past(generating_o) |-> !start_trig_o)
    else $error("start accepted while generating");
  AST_GEN_OUT: assert property (generating_o |-> sample_valid_o)
    else $error("generating without valid sample");
  AST_HOLD: assert property (s_hold |-> $stable(sample_addr_o))
    else $error("held sample moved");
endmodule : wtc_properties

bind wtc_trigger_ctrl wtc_properties u_wtc_properties (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .generating_o,
  .sample_valid_o, .sample_addr_o, .start_trig_o
);

/* wtc_trigger_ctrl.sv */
`timescale 1ns/1ps
`include "wtc_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Accepted start moves idle to generating
// - Start trigger is edge, immediate or software only
// - Four script triggers: edge, level, software
// - Script edge latched until clear or consumed
// - Edge polarity selects rising or falling
// - Level trigger asserted while input at level
// - Start source selectable: two front, eight backplane; script source: two front, five backplane
// - All triggers ignored before initiate command
// - Immediate source gives one start pulse
// - Four trigger modes, waveform and sequence
// - Single mode ignores starts after first
// - Final sample held after generation ends
// - Waveform played repeat count plus one times, halt
// - Sequence plays first to last, then halts
// - Continuous loops forever, ignores later starts
// - Stepped plays once per start, ignores busy
//////////////////////////////////////////////////////////////////////////////
module wtc_trigger_ctrl
  import wtc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [1:0]  front_programmable_input_i,
  input  wire logic [7:0]  backplane_trig_i,
  input  wire logic        scr_ready_i,
  input  wire logic [3:0]  scr_consume_i,
  input  wire logic [3:0]  scr_clear_i,
  output logic [3:0]       scr_trig_o,
  output logic             generating_o,
  output logic [7:0]       sample_addr_o,
  output logic             sample_valid_o,
  output logic             start_trig_o
);

  wtc_wb_req_t  req;
  wtc_wb_rsp_t  rsp;
  wtc_scr_ctl_t scr_ctl;

  typedef enum logic [1:0] {WTC_ST_IDLE, WTC_ST_ARMED, WTC_ST_GEN,
                            WTC_ST_HOLD} wtc_state_t;

  logic        initiated_ff;
  logic [31:0] trigcfg_ff;
  logic [31:0] gencfg_ff;
  logic        imm_pend_ff;
  logic        sw_start_ff;
  logic [3:0]  sw_scr_ff;
  logic [9:0]  sync1_ff;
  logic [9:0]  sync2_ff;
  logic [9:0]  sync3_ff;
  logic [3:0]  scr_latch_ff;
  wtc_state_t  state_ff;
  logic [7:0]  sample_ff;
  logic [7:0]  seg_ff;
  logic [7:0]  rep_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;

  logic        wr_stb;
  logic        start_evt;
  logic        start_acc;
  logic [3:0]  scr_evt;
  logic [3:0]  scr_level;
  logic        wave_end;
  wtc_tmode_t  tmode;

  assign req     = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                     adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
  assign scr_ctl = '{consume: scr_consume_i, clear: scr_clear_i};
  // Write lands at the edge where the master samples ack
  assign wr_stb  = req.cyc & req.stb & req.we & ack_ff;
  assign tmode   = wtc_tmode_t'(gencfg_ff[`WTC_TMODE_LSB +: 2]);

  // Pick synchronised line; 0 is immediate, 1..10 external
  function automatic logic pick(input logic [9:0] v, input wtc_src_t s);
    logic r;
    r = 1'b0;
    if (s != 4'h0 && s <= 4'hA) begin
      r = v[s - 4'h1];
    end
    return r;
  endfunction : pick

  // Edge detect of chosen line with polarity
  function automatic logic edge_of(input wtc_src_t s, input logic pol);
    logic cur;
    logic prv;
    cur = pick(sync2_ff, s);
    prv = pick(sync3_ff, s);
    return pol ? (prv & ~cur) : (cur & ~prv);
  endfunction : edge_of

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  //////////////////////////////////////////////////////////////////////////
  // Bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req.cyc & req.stb & ~ack_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else begin
      unique case (req.adr)
        `WTC_ADR_CTRL:    rdat_ff <= {31'h0000_0000, initiated_ff};
        `WTC_ADR_TRIGCFG: rdat_ff <= trigcfg_ff;
        `WTC_ADR_GENCFG:  rdat_ff <= gencfg_ff;
        `WTC_ADR_SCRIPT:  rdat_ff <= {28'h000_0000, scr_latch_ff};
        `WTC_ADR_STATUS:  rdat_ff <= {28'h000_0000, seg_ff[1:0],
                                      2'(state_ff)};
        `WTC_ADR_SAMPLE:  rdat_ff <= {16'h0000, rep_ff, sample_ff};
        default:          rdat_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign rsp      = '{ack: ack_ff, dat: rdat_ff};
  assign wb_ack_o = rsp.ack;
  assign wb_dat_o = rsp.dat;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trigcfg_ff <= `WTC_TRIGCFG_RST;
      gencfg_ff  <= `WTC_GENCFG_RST;
    end else if (wr_stb && req.adr == `WTC_ADR_TRIGCFG) begin
      trigcfg_ff <= merge(trigcfg_ff, req.dat, req.sel);
    end else if (wr_stb && req.adr == `WTC_ADR_GENCFG) begin
      gencfg_ff  <= merge(gencfg_ff, req.dat, req.sel);
    end
  end

  // Initiate and abort; immediate pulse armed at initiate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      initiated_ff <= 1'b0;
      imm_pend_ff  <= 1'b0;
    end else if (wr_stb && req.adr == `WTC_ADR_CTRL && req.sel[0]) begin
      if (req.dat[`WTC_CTRL_ABORT_BIT]) begin
        initiated_ff <= 1'b0;
        imm_pend_ff  <= 1'b0;
      end else if (req.dat[`WTC_CTRL_INIT_BIT] && !initiated_ff) begin
        initiated_ff <= 1'b1;
        imm_pend_ff  <= 1'b1;
      end
    end else if (imm_pend_ff && scr_ready_i) begin
      imm_pend_ff <= 1'b0;
    end
  end

  // Software trigger commands become one-cycle internal events
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_start_ff <= 1'b0;
      sw_scr_ff   <= 4'h0;
    end else if (wr_stb && req.adr == `WTC_ADR_CMD && req.sel[0]) begin
      sw_start_ff <= req.dat[`WTC_CMD_SWSTART_BIT];
      sw_scr_ff   <= req.dat[`WTC_CMD_SWSCR_LSB +: 4];
    end else begin
      sw_start_ff <= 1'b0;
      sw_scr_ff   <= 4'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and trigger qualification
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 10'h000;
      sync2_ff <= 10'h000;
      sync3_ff <= 10'h000;
    end else begin
      sync1_ff <= {backplane_trig_i, front_programmable_input_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Start: edge, immediate or software only, no level option
  always_comb begin
    start_evt = 1'b0;
    if (initiated_ff) begin
      if (trigcfg_ff[`WTC_START_SW_BIT]) begin
        start_evt = sw_start_ff;
      end else if (trigcfg_ff[`WTC_START_SRC_LSB +: 4] == 4'h0) begin
        start_evt = imm_pend_ff & scr_ready_i;
      end else begin
        start_evt = edge_of(trigcfg_ff[`WTC_START_SRC_LSB +: 4],
                            trigcfg_ff[`WTC_START_POL_BIT]);
      end
    end
  end

  always_comb begin
    scr_evt   = 4'h0;
    scr_level = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (initiated_ff) begin
        unique case (wtc_ttype_t'(trigcfg_ff[`WTC_SCR_TYPE_LSB + 2*i +: 2]))
          WTC_TYPE_EDGE:  scr_evt[i] = edge_of(
                            {1'b0, trigcfg_ff[`WTC_SCR_SRC_LSB + 3*i +: 3]},
                            trigcfg_ff[`WTC_SCR_POL_LSB + i]);
          WTC_TYPE_LEVEL: scr_level[i] = pick(sync2_ff,
                            {1'b0, trigcfg_ff[`WTC_SCR_SRC_LSB + 3*i +: 3]})
                            ^ trigcfg_ff[`WTC_SCR_POL_LSB + i];
          WTC_TYPE_SOFT:  scr_evt[i] = sw_scr_ff[i];
          default:        scr_evt[i] = 1'b0;
        endcase
      end
    end
  end

  // Edge and software script triggers latch; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !initiated_ff) begin
      scr_latch_ff <= 4'h0;
    end else begin
      scr_latch_ff <= (scr_latch_ff & ~(scr_ctl.clear | scr_ctl.consume))
                      | scr_evt;
    end
  end

  assign scr_trig_o = scr_latch_ff | scr_level;

  //////////////////////////////////////////////////////////////////////////
  // Generation sequencer
  assign wave_end = sample_ff == gencfg_ff[`WTC_WLEN_LSB +: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i || !initiated_ff) begin
      state_ff  <= WTC_ST_IDLE;
      sample_ff <= 8'h00;
      seg_ff    <= 8'h00;
      rep_ff    <= 8'h00;
    end else begin
      unique case (state_ff)
        WTC_ST_IDLE, WTC_ST_ARMED: begin
          state_ff <= WTC_ST_ARMED;
          if (start_evt) begin
            state_ff  <= WTC_ST_GEN;
            sample_ff <= 8'h00;
            rep_ff    <= 8'h00;
          end
        end
        WTC_ST_GEN: begin
          sample_ff <= sample_ff + 8'h01;
          if (wave_end) begin
            sample_ff <= 8'h00;
            if (rep_ff < gencfg_ff[`WTC_REPEAT_LSB +: 8]) begin
              rep_ff <= rep_ff + 8'h01;
            end else begin
              rep_ff <= 8'h00;
              if (!gencfg_ff[`WTC_OMODE_BIT]) begin
                if (tmode != WTC_TM_CONTINUOUS) begin
                  sample_ff <= sample_ff;
                  state_ff  <= WTC_ST_HOLD;
                end
              end else if (seg_ff == gencfg_ff[`WTC_SEGS_LSB +: 8]) begin
                seg_ff <= 8'h00;
                if (tmode != WTC_TM_CONTINUOUS) begin
                  sample_ff <= sample_ff;
                  state_ff  <= WTC_ST_HOLD;
                end
              end else begin
                seg_ff <= seg_ff + 8'h01;
                if (tmode == WTC_TM_STEPPED) begin
                  sample_ff <= sample_ff;
                  state_ff  <= WTC_ST_HOLD;
                end
              end
            end
          end
        end
        WTC_ST_HOLD: begin
          if (tmode == WTC_TM_STEPPED && start_evt) begin
            state_ff  <= WTC_ST_GEN;
            sample_ff <= 8'h00;
          end
        end
      endcase
    end
  end

  assign generating_o   = state_ff == WTC_ST_GEN;
  assign sample_valid_o = state_ff == WTC_ST_GEN || state_ff == WTC_ST_HOLD;
  assign sample_addr_o  = sample_ff;
  // Starts while busy or after a finished single run are dropped
  assign start_acc = start_evt & (state_ff != WTC_ST_GEN)
                     & (state_ff != WTC_ST_HOLD || tmode == WTC_TM_STEPPED);
  assign start_trig_o   = start_acc;

endmodule : wtc_trigger_ctrl
